//--- rtl/frtc_cfg.svh
`ifndef FRTC_CFG_SVH
`define FRTC_CFG_SVH

`define FRTC_A_CNT_HI    8'h00
`define FRTC_A_CNT_LO    8'h04
`define FRTC_A_SHD_HI    8'h08
`define FRTC_A_SHD_LO    8'h0c
`define FRTC_A_STATUS    8'h10
`define FRTC_A_CTRL_ONE  8'h14
`define FRTC_A_CTRL_TWO  8'h18
`define FRTC_A_IRQ_MASK  8'h1c
`define FRTC_A_SYS       8'h20

`define FRTC_CNT_RESET   16'hfffc
`define FRTC_CNT_WRAP    16'hffff

`define FRTC_B_OVF       0
`define FRTC_B_OVERFLOW_IRQ_ENABLE      5
`define FRTC_B_EDGE      0
`define FRTC_B_CC_LO     2
`define FRTC_B_HALT      0
`define FRTC_B_IMASK     1

`define FRTC_CC_DIV4     2'b00
`define FRTC_CC_DIV2     2'b01
`define FRTC_CC_DIV8     2'b10
`define FRTC_CC_EXT      2'b11

`define FRTC_PRE_W       3

`endif

//--- rtl/frtc_pkg.sv
package frtc_pkg;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } frtc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } frtc_apb_rsp_t;

    typedef enum logic [1:0] {
        FRTC_RD_LIVE = 2'b01,
        FRTC_RD_HELD = 2'b10
    } frtc_rd_state_t;

    typedef struct packed {
        logic [15:0]    count;
        logic [7:0]     lo_buf;
        frtc_rd_state_t rd_st;
        logic           ovf;
        logic           ovf_armed;
        logic           irq_en;
        logic           irq_mask;
        logic [1:0]     clk_sel;
        logic           edge_sel;
        logic           halt;
        logic           cpu_imask;
        logic [2:0]     pre;
        logic           ext_d;
        logic           ext_tick;
    } frtc_state_t;

endpackage

//--- rtl/frtc_timer.sv
// Behaviour
// - 16-bit up counter, read as two bytes
// - clock from cpu/2, /4, /8 or external
// - field value 11 selects external clock
// - edge select bit picks external active edge
// - external ticks aligned to cpu clock
// - reset and low-byte write load fffc
// - high-byte read freezes low byte buffer
// - unpreceded low read returns live byte
// - wrap ffff to 0000 sets overflow flag
// - interrupt needs enable and cpu mask clear
// - flag clears after status read, low access
// - shadow view never clears overflow flag
// - counting continues in wait mode
// - halt freezes count, resumes held value
// - unbonded input pin reads as one
// - instances start together from reset
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "frtc_cfg.svh"

module frtc_timer (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire frtc_pkg::frtc_apb_req_t apb_req,
    output var  frtc_pkg::frtc_apb_rsp_t apb_rsp,
    input  wire logic                    ext_clock_pin,
    input  wire logic                    ext_clock_bonded,
    output logic                         irq
);
    import frtc_pkg::*;

    frtc_state_t s_r;
    frtc_state_t s_nxt;

    logic        wr_en;
    logic        rd_en;
    logic        ext_level;
    logic        tick;
    logic [7:0]  lo_sel;
    logic [31:0] rdata;
    logic        hit;

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    // unbonded pin sensed high
    assign ext_level = ext_clock_bonded ? ext_clock_pin : 1'b1;

    always_comb begin
        case (s_r.clk_sel)
            `FRTC_CC_DIV2: tick = s_r.pre[0];
            `FRTC_CC_DIV4: tick = &s_r.pre[1:0];
            `FRTC_CC_DIV8: tick = &s_r.pre;
            `FRTC_CC_EXT:  tick = s_r.ext_tick;
            default:       tick = 1'b0;
        endcase
    end

    // live byte unless a high read has frozen the buffer
    assign lo_sel = (s_r.rd_st == FRTC_RD_HELD) ? s_r.lo_buf
                                                : s_r.count[7:0];

    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (apb_req.paddr)
            `FRTC_A_CNT_HI, `FRTC_A_SHD_HI: rdata[7:0] = s_r.count[15:8];
            `FRTC_A_CNT_LO, `FRTC_A_SHD_LO: rdata[7:0] = lo_sel;
            `FRTC_A_STATUS:   rdata[`FRTC_B_OVF] = s_r.ovf;
            `FRTC_A_CTRL_ONE: rdata[`FRTC_B_OVERFLOW_IRQ_ENABLE] = s_r.irq_en;
            `FRTC_A_CTRL_TWO: rdata[3:0] = {s_r.clk_sel, 1'b0, s_r.edge_sel};
            `FRTC_A_IRQ_MASK: rdata[`FRTC_B_OVF] = s_r.irq_mask;
            `FRTC_A_SYS:      rdata[1:0] = {s_r.cpu_imask, s_r.halt};
            default:          hit = 1'b0;
        endcase
    end

    always_comb begin
        logic lo_main;
        logic lo_any;
        logic wrap;
        lo_main = is_addr(apb_req.paddr, `FRTC_A_CNT_LO);
        lo_any  = lo_main | is_addr(apb_req.paddr, `FRTC_A_SHD_LO);
        wrap    = 1'b0;
        s_nxt   = s_r;
        s_nxt.ext_tick = 1'b0;

        // prescaler and edge detect stop during halt, wait has no effect
        if (!s_r.halt) begin
            s_nxt.pre   = s_r.pre + 3'd1;
            s_nxt.ext_d = ext_level;
            // registered edge pulse keeps counter on cpu clock domain
            s_nxt.ext_tick = (s_r.edge_sel ? (ext_level & ~s_r.ext_d)
                                           : (~ext_level & s_r.ext_d));
        end

        if (tick && !s_r.halt) begin
            s_nxt.count = s_r.count + 16'd1;
            wrap = (s_r.count == `FRTC_CNT_WRAP);
        end

        if (rd_en) begin
            if (is_addr(apb_req.paddr, `FRTC_A_CNT_HI) ||
                is_addr(apb_req.paddr, `FRTC_A_SHD_HI)) begin
                // buffer only on the first high read of a sequence
                if (s_r.rd_st == FRTC_RD_LIVE) begin
                    s_nxt.lo_buf = s_r.count[7:0];
                end
                s_nxt.rd_st = FRTC_RD_HELD;
            end
            if (lo_any) begin
                s_nxt.rd_st = FRTC_RD_LIVE;
            end
            if (is_addr(apb_req.paddr, `FRTC_A_STATUS) && s_r.ovf) begin
                s_nxt.ovf_armed = 1'b1;
            end
        end

        if (wr_en) begin
            if (lo_any) begin
                s_nxt.count = `FRTC_CNT_RESET;
                s_nxt.pre   = 3'd0;
                s_nxt.rd_st = FRTC_RD_LIVE;
                wrap        = 1'b0;
            end
            case (apb_req.paddr)
                `FRTC_A_CTRL_ONE: s_nxt.irq_en = apb_req.pwdata[`FRTC_B_OVERFLOW_IRQ_ENABLE];
                `FRTC_A_CTRL_TWO: begin
                    s_nxt.clk_sel  = apb_req.pwdata[`FRTC_B_CC_LO +: 2];
                    s_nxt.edge_sel = apb_req.pwdata[`FRTC_B_EDGE];
                end
                `FRTC_A_IRQ_MASK: s_nxt.irq_mask = apb_req.pwdata[`FRTC_B_OVF];
                `FRTC_A_SYS: begin
                    s_nxt.halt      = apb_req.pwdata[`FRTC_B_HALT];
                    s_nxt.cpu_imask = apb_req.pwdata[`FRTC_B_IMASK];
                end
                `FRTC_A_STATUS: begin
                    if (apb_req.pwdata[`FRTC_B_OVF]) begin
                        s_nxt.ovf       = 1'b0;
                        s_nxt.ovf_armed = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // two-step clear through main low byte; shadow view excluded
        if ((rd_en || wr_en) && lo_main && s_r.ovf_armed) begin
            s_nxt.ovf       = 1'b0;
            s_nxt.ovf_armed = 1'b0;
        end

        // a wrap in the clearing cycle keeps the flag
        if (wrap) begin
            s_nxt.ovf       = 1'b1;
            s_nxt.ovf_armed = 1'b0;
        end
    end

    // every instance leaves reset at fffc with a zero prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r           <= '0;
            s_r.count     <= `FRTC_CNT_RESET;
            s_r.rd_st     <= FRTC_RD_LIVE;
            s_r.irq_mask  <= 1'b1;
            s_r.ext_d     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // pending flag held until enable, irq_mask and cpu mask allow it
    assign irq = s_r.ovf & s_r.irq_en & s_r.irq_mask & ~s_r.cpu_imask;

    always_comb begin
        apb_rsp.prdata  = rd_en ? rdata : 32'h0000_0000;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
    end

endmodule
`default_nettype wire

//--- tb/frtc_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module frtc_props (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire frtc_pkg::frtc_apb_req_t apb_req,
    input wire frtc_pkg::frtc_apb_rsp_t apb_rsp,
    input wire logic                    irq
);
    import frtc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic rda = acc && !apb_req.pwrite;
    wire logic map = apb_req.paddr <= 8'h20 && apb_req.paddr[1:0] == 2'h0;
    sequence s_wr_lo;
        acc && apb_req.pwrite && apb_req.paddr inside {8'h04, 8'h0c};
    endsequence
    sequence s_set_hi;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite
            && apb_req.paddr inside {8'h00, 8'h08};
    endsequence
    property p_reload;
        s_wr_lo ##1 s_set_hi |=> apb_rsp.prdata[7:0] == 8'hff;
    endproperty
    property p_ready; acc |-> apb_rsp.pready; endproperty
    property p_rdz; !rda |-> apb_rsp.prdata == 32'h0; endproperty
    property p_err;
        acc && !map |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
    endproperty
    property p_ok; acc && map |-> !apb_rsp.pslverr; endproperty
    property p_byte;
        rda && apb_req.paddr <= 8'h0c |-> apb_rsp.prdata[31:8] == 24'h0;
    endproperty
    property p_fell; $fell(irq) |-> $past(acc); endproperty
    property p_rst; $rose(presetn) |-> !irq; endproperty
    a_reload: assert property (p_reload) else $error("reload");
    a_ready: assert property (p_ready) else $error("ready");
    a_rdz: assert property (p_rdz) else $error("rdata");
    a_err: assert property (p_err) else $error("unmapped");
    a_ok: assert property (p_ok) else $error("slverr");
    a_byte: assert property (p_byte) else $error("byte");
    a_fell: assert property (p_fell) else $error("irq drop");
    a_rst: assert property (p_rst) else $error("irq reset");
endmodule
bind frtc_timer frtc_props u_frtc_props (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq(irq));
`default_nettype wire

//--- tb/frtc_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module frtc_timer_bench;
    import frtc_pkg::*;
    logic          pclk, presetn, pin, bond, irq;
    frtc_apb_req_t rq;
    frtc_apb_rsp_t rs;
    logic [31:0]   rd, a;
    integer        seed, m;
    int            num_errors, num_checks;
    frtc_timer u_frtc_timer (.pclk(pclk), .presetn(presetn),
        .apb_req(rq), .apb_rsp(rs), .ext_clock_pin(pin),
        .ext_clock_bonded(bond), .irq(irq));
    function automatic int per(input int c);
        return c == 1 ? 2 : c == 0 ? 4 : 8;
    endfunction
    task automatic chk(input logic [31:0] s, e, input string n);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd);
        rq <= '{ad, 1'b1, 1'b0, w, wd};
        @(posedge pclk);
        rq.penable <= 1'b1;
        do @(posedge pclk); while (rs.pready !== 1'b1);
        rd = rs.prdata;
    endtask
    task automatic rc(input logic [7:0] ad, input logic [31:0] e,
                      input string n);
        bus(1'b0, ad, 32'h0);
        chk(rd, e, n);
    endtask
    task automatic idle(input int n);
        rq.psel <= 1'b0;
        rq.penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        seed = 94;
        {presetn, pin, bond} = 3'h1;
        rq = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b1, 8'h20, 32'h1);
        bus(1'b1, 8'h04, 32'h0);
        rc(8'h00, 32'hff, "reload_hi");
        idle(20);
        rc(8'h00, 32'hff, "cnt_hi");
        rc(8'h04, 32'hfc, "cnt_lo");
        rc(8'h08, 32'hff, "shd_hi");
        rc(8'h0c, 32'hfc, "shd_lo");
        rc(8'h24, 32'h0, "unmapped");
        bus(1'b1, 8'h14, 32'h20);
        bus(1'b1, 8'h18, 32'h4);
        bus(1'b1, 8'h20, 32'h2);
        idle(30);
        chk(32'(irq), 32'h0, "irq_held");
        rc(8'h10, 32'h1, "ovf");
        bus(1'b1, 8'h20, 32'h0);
        idle(2);
        chk(32'(irq), 32'h1, "irq");
        bus(1'b1, 8'h1c, 32'h0);
        idle(2);
        chk(32'(irq), 32'h0, "irq_mask");
        bus(1'b1, 8'h1c, 32'h1);
        bus(1'b0, 8'h0c, 32'h0);
        rc(8'h10, 32'h1, "ovf_kept");
        bus(1'b0, 8'h04, 32'h0);
        idle(2);
        chk(32'(irq), 32'h0, "irq_clr");
        rc(8'h10, 32'h0, "ovf_clr");
        // divide ratios in the order div8, div4, div2
        for (int c = 2; c < 5; c++) begin
            bus(1'b1, 8'h18, 32'(c % 3) << 2);
            bus(1'b1, 8'h0c, 32'h0);
            m = 2 + {$random(seed)} % 6;
            bus(1'b0, 8'h0c, 32'h0);
            a = rd + m;
            idle(m * per(c % 3) - 2);
            rc(8'h0c, a & 32'hff, "rate");
        end
        bus(1'b0, 8'h04, 32'h0);
        a = rd + 1;
        bus(1'b0, 8'h00, 32'h0);
        idle(2 + {$random(seed)} % 9);
        bus(1'b0, 8'h00, 32'h0);
        rc(8'h04, a & 32'hff, "held_lo");
        bus(1'b0, 8'h04, 32'h0);
        a = rd + 2;
        idle(2);
        rc(8'h04, a & 32'hff, "live_lo");
        // falling, rising, then falling with the pin not bonded
        for (int c = 0; c < 3; c++) begin
            bond <= (c < 2);
            pin <= 1'b0;
            bus(1'b1, 8'h18, 32'hc | c[0]);
            idle(4);
            bus(1'b0, 8'h0c, 32'h0);
            m = {$random(seed)} % 4;
            a = rd + (c == 2 ? 0 : m + c[0]);
            repeat (2 * m + 1) begin
                pin <= ~pin;
                idle(4);
            end
            rc(8'h0c, a & 32'hff, "ext");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
